// ==== tb/watchdog_interval_timer_bench.sv ====
`include "wdt_map.svh"

module watchdog_interval_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;

   ////////////////////////////////////////////////////////////////////////////////
   // Register indexes and keyed write words
   localparam logic [17:0] i_ctrl = `WDT_IDX_CTRL;
   localparam logic [17:0] i_cnt = `WDT_IDX_CNT;
   localparam logic [17:0] i_rw = `WDT_IDX_RST_WR;
   localparam logic [17:0] i_rr = `WDT_IDX_RST_RD;
   localparam logic [17:0] i_st = `WDT_IDX_IRQ_STAT;
   localparam logic [17:0] i_en = `WDT_IDX_IRQ_EN;
   localparam logic [17:0] i_clr = `WDT_IDX_IRQ_CLR;
   localparam logic [31:0] k_ctrl = {16'h0000, `WDT_KEY_CTRL, 8'h00};
   localparam logic [31:0] k_cnt = {16'h0000, `WDT_KEY_CNT, 8'h00};
   localparam logic [31:0] k_rst = {16'h0000, `WDT_KEY_RST, 8'h00};

   ////////////////////////////////////////////////////////////////////////////////
   // Design ports
   logic pclk = 1'b0; // Bus clock, 20 ns period
   logic presetn = 1'b0; // Held low at start
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [19:0] paddr = 20'h00000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hf; // Full word writes only
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic expiry_output_pin;
   logic poweron_reset_req;
   logic manual_reset_req;
   logic interval_interrupt;
   logic irq;

   // Bench bookkeeping
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0; // Clock cycles since time zero
   int n_exp = 0; // Expiry pulses seen
   int n_por = 0; // Power-on reset requests seen
   int n_man = 0; // Manual reset requests seen
   int last_t = 0; // Cycle of latest expiry pulse
   int prev_t = 0; // Cycle of the one before
   int e;

   // Clock
   always #10 pclk = ~pclk;

   watchdog_interval_timer uut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .expiry_output_pin(expiry_output_pin),
      .poweron_reset_req(poweron_reset_req),
      .manual_reset_req(manual_reset_req),
      .interval_interrupt(interval_interrupt),
      .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Counts output pulses and stamps the expiry pulses
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (expiry_output_pin === 1'b1) begin
         prev_t = last_t;
         last_t = cyc;
         n_exp = n_exp + 1;
      end
      if (poweron_reset_req === 1'b1) n_por = n_por + 1;
      if (manual_reset_req === 1'b1) n_man = n_man + 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compares and counts one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   // One bus transfer: setup, then access until pready is sampled high
   task automatic xfer(input logic w, input logic [17:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 32);
      rd = prdata;
      er = pslverr;
      if (pready !== 1'b1) chk({31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Write and compare the error response
   task automatic wr(input logic [17:0] idx, input logic [31:0] wd, input logic eexp);
      logic [31:0] rd;
      logic er;
      xfer(1'b1, idx, wd, rd, er);
      chk({31'h0, er}, {31'h0, eexp});
   endtask

   // Read and compare the error response and, if accepted, the data
   task automatic rdc(input logic [17:0] idx, input logic [31:0] dexp, input logic eexp);
      logic [31:0] rd;
      logic er;
      xfer(1'b0, idx, 32'h00000000, rd, er);
      chk({31'h0, er}, {31'h0, eexp});
      if (!eexp) chk(rd, dexp);
   endtask

   // Waits until the expiry pulse count reaches a target, bounded
   task automatic wait_exp(input int target);
      int n;
      n = 0;
      while (n_exp < target && n < 40000) begin
         @(posedge pclk);
         n++;
      end
      @(posedge pclk);
   endtask

   // Prints the verdict and ends the run
   task automatic finish_test;
      if (num_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog against a hung run
   initial begin
      repeat (90000) @(posedge pclk);
      num_errors++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int n;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values
      rdc(i_ctrl, 32'h18, 1'b0);
      rdc(i_rr, 32'h1f, 1'b0);
      rdc(i_cnt, 32'h00, 1'b0);
      rdc(i_st, 32'h0, 1'b0);
      rdc(i_clr, 32'h0, 1'b0);
      // Unkeyed writes and wrong places refused
      wr(i_ctrl, 32'h00000020, 1'b1);
      wr(i_cnt, 32'h00000055, 1'b1);
      wr(i_rw, 32'h00000040, 1'b1);
      rdc(i_ctrl, 32'h18, 1'b0);
      rdc(i_rw, 32'h0, 1'b1);
      wr(i_rr, k_rst | 32'h40, 1'b1);
      rdc(i_rr, 32'h1f, 1'b0);
      rdc(18'h00000, 32'h0, 1'b1);
      // Flags cannot be set by writing one; stopped counter ignores writes
      wr(i_ctrl, k_ctrl | 32'h80, 1'b0);
      rdc(i_ctrl, 32'h18, 1'b0);
      wr(i_rw, k_rst | 32'h80, 1'b0);
      rdc(i_rr, 32'h1f, 1'b0);
      wr(i_cnt, k_cnt | 32'h33, 1'b0);
      rdc(i_cnt, 32'h00, 1'b0);
      // Interval mode overflow
      wr(i_en, 32'h3, 1'b0);
      wr(i_ctrl, k_ctrl | 32'h20, 1'b0);
      n = 0;
      while (interval_interrupt !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, interval_interrupt}, 32'h1);
      // Interrupt level follows the sticky status one cycle later
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      chk(n_exp + n_por + n_man, 0);
      rdc(i_ctrl, 32'hb8, 1'b0);
      rdc(i_st, 32'h1, 1'b0);
      // Read-then-zero clears the flag; stopping holds the counter at zero
      wr(i_ctrl, k_ctrl | 32'h00, 1'b0);
      rdc(i_ctrl, 32'h18, 1'b0);
      rdc(i_cnt, 32'h00, 1'b0);
      chk({31'h0, interval_interrupt}, 32'h0);
      // Interrupt masking and clearing
      wr(i_en, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(i_en, 32'h3, 1'b0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      wr(i_clr, 32'h1, 1'b0);
      rdc(i_st, 32'h0, 1'b0);
      chk({31'h0, irq}, 32'h0);
      // Watchdog mode with power-on reset request
      wr(i_rw, k_rst | 32'h40, 1'b0);
      wr(i_ctrl, k_ctrl | 32'h60, 1'b0);
      wait_exp(1);
      chk(n_exp, 1);
      chk(n_por, 1);
      chk(n_man, 0);
      rdc(i_ctrl, 32'h78, 1'b0);
      rdc(i_st, 32'h2, 1'b0);
      rdc(i_rr, 32'hdf, 1'b0);
      // A keyed write between read and zero write spoils the clear
      wr(i_rw, k_rst | 32'hc0, 1'b0);
      wr(i_rw, k_rst | 32'h40, 1'b0);
      rdc(i_rr, 32'hdf, 1'b0);
      wr(i_rw, k_rst | 32'h60, 1'b0);
      rdc(i_rr, 32'h7f, 1'b0);
      // Manual reset request, then none with reset disabled
      wait_exp(2);
      chk(n_man, 1);
      chk(n_por, 1);
      wr(i_rw, k_rst | 32'h00, 1'b0);
      wait_exp(3);
      chk(n_exp, 3);
      chk(n_por + n_man, 2);
      // Overflow period for the two fastest divider codes, after a keyed load
      wr(i_cnt, k_cnt | 32'hf0, 1'b0);
      e = n_exp;
      wait_exp(e + 2);
      chk(last_t - prev_t, 512);
      wr(i_ctrl, k_ctrl | 32'h61, 1'b0);
      e = n_exp;
      wait_exp(e + 2);
      chk(last_t - prev_t, 16384);
      finish_test();
   end
endmodule

// ==== verilog/clock_prescaler.sv ====
`include "wdt_map.svh"

module clock_prescaler (
   input wire logic pclk,
   input wire logic presetn,
   input wire wdt_pkg::div_sel_t div_sel,
   output logic tick_q
);
   ////////////////////////////////////////////////////////////////////////////////
   // Free running divider; a tick every 2^k cycles
   logic [`WDT_PRE_WIDTH-1:0] pre_q; // Divider count

   // Low-bit mask for the chosen divisor
   function automatic logic [`WDT_PRE_WIDTH-1:0] div_mask(input wdt_pkg::div_sel_t s);
      logic [4:0] k;
      k = `WDT_DIV_LOG2_0;
      unique case (s)
         3'h0: k = `WDT_DIV_LOG2_0;
         3'h1: k = `WDT_DIV_LOG2_1;
         3'h2: k = `WDT_DIV_LOG2_2;
         3'h3: k = `WDT_DIV_LOG2_3;
         3'h4: k = `WDT_DIV_LOG2_4;
         3'h5: k = `WDT_DIV_LOG2_5;
         3'h6: k = `WDT_DIV_LOG2_6;
         3'h7: k = `WDT_DIV_LOG2_7;
      endcase
      div_mask = ~({`WDT_PRE_WIDTH{1'b1}} << k);
   endfunction

   // Divider counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // Tick when all selected low bits are ones
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= &(pre_q | ~div_mask(div_sel));
      end
   end
endmodule

// ==== verilog/event_irq_bank.sv ====
`include "wdt_map.svh"

module event_irq_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [`WDT_EV_COUNT-1:0] event_set,
   input wire logic [`WDT_EV_COUNT-1:0] clear_bits,
   input wire logic clear_wr,
   input wire logic [`WDT_EV_COUNT-1:0] enable_bits,
   input wire logic enable_wr,
   output logic [`WDT_EV_COUNT-1:0] status_q,
   output logic [`WDT_EV_COUNT-1:0] enable_q,
   output logic irq_q
);
   ////////////////////////////////////////////////////////////////////////////////
   // Sticky status bits; a new event wins over a clear
   genvar i;
   generate
      for (i = 0; i < `WDT_EV_COUNT; i++) begin : g_stat
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               status_q[i] <= 1'b0;
            end else if (event_set[i]) begin
               status_q[i] <= 1'b1;
            end else if (clear_wr && clear_bits[i]) begin
               status_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // Enable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= '0;
      end else if (enable_wr) begin
         enable_q <= enable_bits;
      end
   end

   // Level interrupt while any enabled status bit is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & enable_q);
      end
   end
endmodule

// ==== verilog/watchdog_interval_timer.sv ====
// Function
// - Counter steps at one of eight prescaled rates
// - Watchdog mode pulses expiry pin on overflow
// - Interval mode sets wrap flag on overflow
// - Flags only cleared by zero, never set
// - Watchdog mode sets expiry flag on overflow
// - Expiry flag clears after read-one then write-zero
// - Reset enable gates overflow reset request
// - Reset select picks power-on or manual
// - Unkeyed writes to timer registers rejected
// - Reset control written low, read next index
//
// Implementation choice: the APB interface to the registers.
`include "wdt_map.svh"

module watchdog_interval_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [19:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic expiry_output_pin,
   output logic poweron_reset_req,
   output logic manual_reset_req,
   output logic interval_interrupt,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0] up_counter_q; // Timer count
   logic wrap_flag_q; // Overflow flag, interval mode
   wdt_pkg::timer_mode_e timer_mode_select_q; // Interval or watchdog
   logic count_run_enable_q; // Counting enabled
   wdt_pkg::div_sel_t clock_divider_select_q; // Prescaler choice
   logic watchdog_expiry_flag_q; // Overflow flag, watchdog mode
   logic expiry_reset_enable_q; // Reset on overflow
   logic reset_kind_select_q; // 0 power-on, 1 manual
   logic wrap_armed_q; // Control read while wrap flag was one
   logic expiry_armed_q; // Reset control read while expiry flag was one
   logic tick; // Prescaled count enable
   logic wrap_ev; // Counter goes from max to zero
   logic [`WDT_EV_COUNT-1:0] irq_status; // Sticky event bits
   logic [`WDT_EV_COUNT-1:0] irq_enable; // Event enables
   logic [17:0] idx; // Word index of access
   logic [7:0] key; // Protection key byte
   logic setup; // First cycle of a transfer
   logic acc_wr; // Write taking effect now
   logic acc_rd; // Read completing now
   logic wr_ctrl; // Keyed control write
   logic wr_cnt; // Keyed counter write
   logic wr_rst; // Keyed reset control write
   logic [7:0] ctrl_view; // Readback of control/status
   logic [7:0] rst_view; // Readback of reset control

   assign idx = paddr[19:2];
   assign key = pwdata[15:8];
   assign setup = psel && !penable;
   assign acc_wr = psel && penable && pready && pwrite;
   assign acc_rd = psel && penable && pready && !pwrite;
   assign wr_ctrl = acc_wr && idx == `WDT_IDX_CTRL && key == `WDT_KEY_CTRL;
   assign wr_cnt = acc_wr && idx == `WDT_IDX_CNT && key == `WDT_KEY_CNT;
   assign wr_rst = acc_wr && idx == `WDT_IDX_RST_WR && key == `WDT_KEY_RST;
   assign wrap_ev = count_run_enable_q && tick && !wr_cnt && up_counter_q == `WDT_COUNT_MAX;
   assign ctrl_view = `WDT_CTRL_FIXED_ONES | {wrap_flag_q, timer_mode_select_q,
                      count_run_enable_q, 2'b00, clock_divider_select_q};
   assign rst_view = `WDT_RST_FIXED_ONES | {watchdog_expiry_flag_q, expiry_reset_enable_q,
                     reset_kind_select_q, 5'h00};

   ////////////////////////////////////////////////////////////////////////////////
   // Submodules
   // Prescaler producing the count enable
   clock_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .div_sel(clock_divider_select_q),
      .tick_q(tick)
   );

   // Sticky interrupt status, enable and clear
   event_irq_bank u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .event_set({wrap_ev && timer_mode_select_q == wdt_pkg::MODE_WATCHDOG,
                  wrap_ev && timer_mode_select_q == wdt_pkg::MODE_INTERVAL}),
      .clear_bits(pwdata[`WDT_EV_COUNT-1:0]),
      .clear_wr(acc_wr && idx == `WDT_IDX_IRQ_CLR),
      .enable_bits(pwdata[`WDT_EV_COUNT-1:0]),
      .enable_wr(acc_wr && idx == `WDT_IDX_IRQ_EN),
      .status_q(irq_status),
      .enable_q(irq_enable),
      .irq_q(irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Up counter: keyed load, hold at zero when stopped, else count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_counter_q <= `WDT_COUNT_ZERO;
      end else if (!count_run_enable_q) begin
         up_counter_q <= `WDT_COUNT_ZERO;
      end else if (wr_cnt) begin
         up_counter_q <= pwdata[7:0];
      end else if (tick) begin
         up_counter_q <= up_counter_q + 8'h01;
      end
   end

   // Control fields of control/status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_mode_select_q <= wdt_pkg::MODE_INTERVAL;
         count_run_enable_q <= 1'b0;
         clock_divider_select_q <= 3'h0;
      end else if (wr_ctrl) begin
         timer_mode_select_q <= wdt_pkg::timer_mode_e'(pwdata[`WDT_CTRL_MODE_BIT]);
         count_run_enable_q <= pwdata[`WDT_CTRL_RUN_BIT];
         clock_divider_select_q <= pwdata[2:0];
      end
   end

   // Arm the wrap flag clear on a read that saw it at one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_armed_q <= 1'b0;
      end else if (acc_rd && idx == `WDT_IDX_CTRL) begin
         wrap_armed_q <= wrap_flag_q;
      end else if (wr_ctrl) begin
         wrap_armed_q <= 1'b0;
      end
   end

   // Wrap flag: set wins; only armed zero write clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_flag_q <= 1'b0;
      end else if (wrap_ev && timer_mode_select_q == wdt_pkg::MODE_INTERVAL) begin
         wrap_flag_q <= 1'b1;
      end else if (wr_ctrl && wrap_armed_q && !pwdata[`WDT_CTRL_WRAP_BIT]) begin
         wrap_flag_q <= 1'b0;
      end
   end

   // Reset control fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         expiry_reset_enable_q <= 1'b0;
         reset_kind_select_q <= 1'b0;
      end else if (wr_rst) begin
         expiry_reset_enable_q <= pwdata[`WDT_RST_ENABLE_BIT];
         reset_kind_select_q <= pwdata[`WDT_RST_KIND_BIT];
      end
   end

   // Arm the expiry flag clear on a read that saw it at one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         expiry_armed_q <= 1'b0;
      end else if (acc_rd && idx == `WDT_IDX_RST_RD) begin
         expiry_armed_q <= watchdog_expiry_flag_q;
      end else if (wr_rst) begin
         expiry_armed_q <= 1'b0;
      end
   end

   // Expiry flag: set wins; only armed zero write clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_expiry_flag_q <= 1'b0;
      end else if (wrap_ev && timer_mode_select_q == wdt_pkg::MODE_WATCHDOG) begin
         watchdog_expiry_flag_q <= 1'b1;
      end else if (wr_rst && expiry_armed_q && !pwdata[`WDT_RST_EXPIRY_BIT]) begin
         watchdog_expiry_flag_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Overflow outputs: one-cycle pulses, interrupt level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         expiry_output_pin <= 1'b0;
         poweron_reset_req <= 1'b0;
         manual_reset_req <= 1'b0;
         interval_interrupt <= 1'b0;
      end else begin
         // Watchdog mode only; interval mode raises neither pin nor reset
         expiry_output_pin <= wrap_ev && timer_mode_select_q == wdt_pkg::MODE_WATCHDOG;
         poweron_reset_req <= wrap_ev && timer_mode_select_q == wdt_pkg::MODE_WATCHDOG
                              && expiry_reset_enable_q && !reset_kind_select_q;
         manual_reset_req <= wrap_ev && timer_mode_select_q == wdt_pkg::MODE_WATCHDOG
                             && expiry_reset_enable_q && reset_kind_select_q;
         // Level request while the wrap flag is up in interval mode
         interval_interrupt <= (wrap_flag_q || wrap_ev)
                               && timer_mode_select_q == wdt_pkg::MODE_INTERVAL;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave: no wait states, answers registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= '0;
            pslverr <= 1'b0;
            if (pwrite) begin
               unique case (paddr[19:2])
                  `WDT_IDX_CTRL: pslverr <= pwdata[15:8] != `WDT_KEY_CTRL;
                  `WDT_IDX_CNT: pslverr <= pwdata[15:8] != `WDT_KEY_CNT;
                  `WDT_IDX_RST_WR: pslverr <= pwdata[15:8] != `WDT_KEY_RST;
                  `WDT_IDX_IRQ_EN, `WDT_IDX_IRQ_CLR: pslverr <= 1'b0;
                  default: pslverr <= 1'b1;
               endcase
            end else begin
               unique case (paddr[19:2])
                  `WDT_IDX_CTRL: prdata <= {24'h000000, ctrl_view};
                  `WDT_IDX_CNT: prdata <= {24'h000000, up_counter_q};
                  `WDT_IDX_RST_RD: prdata <= {24'h000000, rst_view};
                  `WDT_IDX_IRQ_STAT: prdata <= {30'h00000000, irq_status};
                  `WDT_IDX_IRQ_EN: prdata <= {30'h00000000, irq_enable};
                  `WDT_IDX_IRQ_CLR: prdata <= '0;
                  default: pslverr <= 1'b1;
               endcase
            end
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Read that saw the flag, then the write
   sequence expiry_read_seen;
      acc_rd && idx == `WDT_IDX_RST_RD && watchdog_expiry_flag_q;
   endsequence
   // Keyed zero write while the clear is armed, with no overflow in the way
   sequence zero_write_armed;
      expiry_armed_q && wr_rst && !pwdata[`WDT_RST_EXPIRY_BIT] && !wrap_ev;
   endsequence

   count_hold_a: assert property (!count_run_enable_q |=> up_counter_q == 8'h00)
      else $error("counter not held at zero");
   count_step_a: assert property (count_run_enable_q && tick && !wr_cnt
      |=> up_counter_q == $past(up_counter_q) + 8'h01)
      else $error("counter did not step on tick");
   expiry_pin_a: assert property (wrap_ev && timer_mode_select_q == wdt_pkg::MODE_WATCHDOG
      |=> expiry_output_pin ##1 !expiry_output_pin)
      else $error("expiry pin not pulsed");
   wrap_set_a: assert property (wrap_ev && timer_mode_select_q == wdt_pkg::MODE_INTERVAL
      |=> wrap_flag_q && interval_interrupt)
      else $error("wrap flag not set");
   flag_noset_a: assert property (!wrap_ev && !watchdog_expiry_flag_q
      |=> !watchdog_expiry_flag_q)
      else $error("expiry flag set without overflow");
   expiry_set_a: assert property (wrap_ev && timer_mode_select_q == wdt_pkg::MODE_WATCHDOG
      |=> watchdog_expiry_flag_q)
      else $error("expiry flag not set");
   arm_expiry_a: assert property (expiry_read_seen |=> expiry_armed_q)
      else $error("expiry clear not armed by read");
   clear_order_a: assert property (zero_write_armed
      |=> !watchdog_expiry_flag_q)
      else $error("expiry flag not cleared after read then zero");
   wrap_noset_a: assert property (!wrap_ev && !wrap_flag_q |=> !wrap_flag_q)
      else $error("wrap flag set without overflow");
   wrap_clear_a: assert property (wr_ctrl && wrap_armed_q && !pwdata[`WDT_CTRL_WRAP_BIT]
      && !wrap_ev |=> !wrap_flag_q)
      else $error("wrap flag not cleared after read then zero");
   count_load_a: assert property (count_run_enable_q && wr_cnt
      |=> up_counter_q == $past(pwdata[7:0]))
      else $error("keyed counter write not loaded");
   clear_cause_a: assert property ($fell(watchdog_expiry_flag_q) |-> $past(expiry_armed_q))
      else $error("expiry flag cleared without prior read");
   reset_gate_a: assert property (!expiry_reset_enable_q
      |=> !poweron_reset_req && !manual_reset_req)
      else $error("reset requested while disabled");
   reset_kind_a: assert property (wrap_ev && timer_mode_select_q == wdt_pkg::MODE_WATCHDOG
      && expiry_reset_enable_q |=> manual_reset_req == $past(reset_kind_select_q)
      && poweron_reset_req == !$past(reset_kind_select_q))
      else $error("wrong reset kind");
   key_reject_a: assert property (setup && pwrite && paddr[19:2] == `WDT_IDX_CTRL
      && pwdata[15:8] != `WDT_KEY_CTRL |=> pslverr && $stable(count_run_enable_q))
      else $error("unkeyed control write not rejected");
   rst_split_a: assert property (setup && !pwrite && paddr[19:2] == `WDT_IDX_RST_WR
      |=> pslverr)
      else $error("reset control readable at write index");
   interval_quiet_a: assert property (wrap_ev && timer_mode_select_q == wdt_pkg::MODE_INTERVAL
      |=> !expiry_output_pin && !poweron_reset_req && !manual_reset_req)
      else $error("interval overflow caused expiry");
endmodule

// ==== verilog/wdt_map.svh ====
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Register indexes; byte address is four times the index
`define WDT_IDX_CTRL 18'h0ffbc
`define WDT_IDX_CNT 18'h0ffbd
`define WDT_IDX_RST_WR 18'h0ffbe
`define WDT_IDX_RST_RD 18'h0ffbf
`define WDT_IDX_IRQ_STAT 18'h0ffc4
`define WDT_IDX_IRQ_EN 18'h0ffc5
`define WDT_IDX_IRQ_CLR 18'h0ffc6

// Protection keys carried in write data bits 15:8
`define WDT_KEY_CTRL 8'h5a
`define WDT_KEY_CNT 8'h69
`define WDT_KEY_RST 8'ha5

// Control/status field positions and reset value
`define WDT_CTRL_WRAP_BIT 7
`define WDT_CTRL_MODE_BIT 6
`define WDT_CTRL_RUN_BIT 5
`define WDT_CTRL_FIXED_ONES 8'h18
`define WDT_CTRL_RESET 8'h18

// Reset control field positions and reset value
`define WDT_RST_EXPIRY_BIT 7
`define WDT_RST_ENABLE_BIT 6
`define WDT_RST_KIND_BIT 5
`define WDT_RST_FIXED_ONES 8'h1f
`define WDT_RST_RESET 8'h1f

// Interrupt event bits
`define WDT_EV_INTERVAL 0
`define WDT_EV_EXPIRY 1
`define WDT_EV_COUNT 2

// Prescaler: log2 of divisor for each select code
`define WDT_PRE_WIDTH 17
`define WDT_DIV_LOG2_0 5'd1
`define WDT_DIV_LOG2_1 5'd6
`define WDT_DIV_LOG2_2 5'd7
`define WDT_DIV_LOG2_3 5'd9
`define WDT_DIV_LOG2_4 5'd11
`define WDT_DIV_LOG2_5 5'd13
`define WDT_DIV_LOG2_6 5'd15
`define WDT_DIV_LOG2_7 5'd17

`define WDT_COUNT_MAX 8'hff
`define WDT_COUNT_ZERO 8'h00

`endif

// ==== verilog/wdt_pkg.sv ====
package wdt_pkg;
   // Counter operating mode
   typedef enum logic {
      MODE_INTERVAL = 1'b0,
      MODE_WATCHDOG = 1'b1
   } timer_mode_e;
   // Divider select code
   typedef logic [2:0] div_sel_t;
endpackage
